// >>> core/strap_config_params.svh
// Constants for strap capture and indexed configuration access.
//
// Overview of operation
// - Seven straps sampled at power-on load enable, base and interrupt; low loads zeros.
// - Channel D strap: 0x2E8 irq 9; channel C: 0x3E8 irq 5; watchdog 0x442.
// - Channel B 0x2E0/0x2F8 irq 4; channel A 0x3E0/0x3F8 irq 3; both high pick F8.
// - Host may rewrite strap-loaded registers; written values then take effect.
// - Index/data ports at 0x2E/0x2F with port strap high, else 0x4E/0x4F.
// - Index port selects a register; data port reads or writes that register.
// - Configuration mode opens only after two consecutive matching key writes.
// - Key straps 00/01/10/11 select entry key 0x77/0xA0/0x87/0x67.
// - Writing 0xAA to the index port closes configuration mode.
// - Selector at index 0x07 picks the logical device for per-device registers.
// - Clock select at index 0x25 written with 1 picks the 48 MHz clock.
// - FIFO mode 0x3 at index 0xF6 gives the selected channel a 128-byte FIFO.
// - Indexes 0x20 and 0x21 return device identification high and low bytes.
// - Writing 1 to index 0x30 enables the selected device at its base.
// - Clock select written with 0 picks the 24 MHz clock.
// - Selector value 0 picks channel A.
`ifndef STRAP_CONFIG_PARAMS_SVH
`define STRAP_CONFIG_PARAMS_SVH

`define IDX_DEVICE_SELECT 8'h07
`define IDX_ID_HIGH 8'h20
`define IDX_ID_LOW 8'h21
`define IDX_CLOCK_SELECT 8'h25
`define IDX_ENABLE 8'h30
`define IDX_BASE_HIGH 8'h60
`define IDX_BASE_LOW 8'h61
`define IDX_IRQ_SELECT 8'h70
`define IDX_FIFO_MODE 8'hf6

`define PORT_INDEX_HI 16'h002e
`define PORT_DATA_HI 16'h002f
`define PORT_INDEX_LO 16'h004e
`define PORT_DATA_LO 16'h004f

`define KEY_CODE_00 8'h77
`define KEY_CODE_01 8'ha0
`define KEY_CODE_10 8'h87
`define KEY_CODE_11 8'h67
`define EXIT_CODE 8'haa

`define LDN_WATCHDOG 8'h08
`define FIFO_DEEP_CODE 2'h3
`define FIFO_MODE_RESET 8'h00
`define CLOCK_SELECT_RESET 8'h00

`define BASE_CHAN_D 16'h02e8
`define IRQ_CHAN_D 8'h09
`define BASE_CHAN_C 16'h03e8
`define IRQ_CHAN_C 8'h05
`define BASE_CHAN_B_ALT 16'h02e0
`define BASE_CHAN_B 16'h02f8
`define IRQ_CHAN_B 8'h04
`define BASE_CHAN_A_ALT 16'h03e0
`define BASE_CHAN_A 16'h03f8
`define IRQ_CHAN_A 8'h03
`define BASE_WATCHDOG 16'h0442
`define IRQ_WATCHDOG 8'h00

`endif

// >>> core/strap_config_pkg.sv
// Types shared by the strap sampler and the configuration register bank.
`default_nettype none
package strap_config_pkg;
  localparam int NUM_DEV = 5;
  localparam int NUM_CHAN = 4;
  localparam int NUM_STRAP = 10;

  typedef enum logic [2:0]
  {
    LOCKED = 3'b001,
    KEY_SEEN = 3'b010,
    CONFIG_OPEN = 3'b100
  } unlock_e;

  typedef logic [7:0] byte_t;

  typedef struct packed
  {
    logic done;
    logic pulse;
    logic [NUM_STRAP-1:0] straps;
  } sampler_s;

  typedef struct packed
  {
    unlock_e state;
    byte_t index;
    byte_t deviceSelect;
    byte_t clockSelect;
    logic [NUM_DEV-1:0] enable;
    logic [NUM_DEV-1:0][7:0] baseHigh;
    logic [NUM_DEV-1:0][7:0] baseLow;
    logic [NUM_DEV-1:0][7:0] irqSelect;
    logic [NUM_CHAN-1:0][7:0] fifoMode;
    byte_t rdData;
    logic rdValid;
  } config_s;
endpackage
`default_nettype wire

// >>> core/strap_config_port_access.sv
// Index/data port configuration register bank with strap-loaded defaults.
`include "strap_config_params.svh"
`default_nettype none
module strap_config_port_access
#(
  // Identification bytes; the values are arbitrary.
  parameter logic [7:0] ID_HIGH = 8'h5a,
  parameter logic [7:0] ID_LOW = 8'h01
)
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic ioWrite,
  input wire logic ioRead,
  input wire logic [15:0] ioAddr,
  input wire logic [7:0] ioWrData,
  output logic ioClaim,
  output logic [7:0] ioRdData,
  output logic ioRdValid,
  input wire logic chanAStrap,
  input wire logic chanAAltStrap,
  input wire logic chanBStrap,
  input wire logic chanBAltStrap,
  input wire logic chanCStrap,
  input wire logic chanDStrap,
  input wire logic watchdogStrap,
  input wire logic configPortStrap,
  input wire logic entryKeyStrapHi,
  input wire logic entryKeyStrapLo,
  output logic configMode,
  output logic clockSelect48,
  output logic [4:0] devEnable,
  output logic [79:0] devBase,
  output logic [39:0] devIrqSelect,
  output logic [31:0] chanFifoMode,
  output logic [3:0] chanFifoDeep
);
  strap_config_pkg::config_s c_q;
  strap_config_pkg::config_s c_d;
  logic loadPulse;
  logic configPortHigh;
  logic [7:0] entryKey;
  logic [4:0] defEnable;
  logic [79:0] defBase;
  logic [39:0] defIrq;
  logic [15:0] indexPort;
  logic [15:0] dataPort;
  logic hitIndex;
  logic hitData;
  logic slotValid;
  logic [2:0] slot;
  logic isChan;

  // ----------------------------------------------------------------------
  // Strap capture
  // ----------------------------------------------------------------------
  strap_sampler u_sampler
  (
    .clock(clock),
    .rstn(rstn),
    .chanAStrap(chanAStrap),
    .chanAAltStrap(chanAAltStrap),
    .chanBStrap(chanBStrap),
    .chanBAltStrap(chanBAltStrap),
    .chanCStrap(chanCStrap),
    .chanDStrap(chanDStrap),
    .watchdogStrap(watchdogStrap),
    .configPortStrap(configPortStrap),
    .entryKeyStrapHi(entryKeyStrapHi),
    .entryKeyStrapLo(entryKeyStrapLo),
    .loadPulse(loadPulse),
    .configPortHigh(configPortHigh),
    .entryKey(entryKey),
    .defEnable(defEnable),
    .defBase(defBase),
    .defIrq(defIrq)
  );

  // ----------------------------------------------------------------------
  // Port decode
  // ----------------------------------------------------------------------
  // port pair
  assign indexPort = configPortHigh ? `PORT_INDEX_HI : `PORT_INDEX_LO;
  assign dataPort = configPortHigh ? `PORT_DATA_HI : `PORT_DATA_LO;
  assign hitIndex = (ioAddr == indexPort);
  assign hitData = (ioAddr == dataPort) && (c_q.state == strap_config_pkg::CONFIG_OPEN);
  assign ioClaim = (ioWrite | ioRead) & (hitIndex | hitData);

  always_comb
  begin
    slotValid = 1'b1;
    slot = 3'd0;
    if (c_q.deviceSelect < 8'd4)
    begin
      slot = c_q.deviceSelect[2:0];
    end
    else if (c_q.deviceSelect == `LDN_WATCHDOG)
    begin
      slot = 3'd4;
    end
    else
    begin
      slotValid = 1'b0;
    end
  end
  assign isChan = slotValid && (slot < 3'd4);

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb
  begin
    c_d = c_q;
    c_d.rdValid = 1'b0;
    if (loadPulse)
    begin
      c_d.enable = defEnable;
      c_d.baseHigh = '0;
      c_d.baseLow = '0;
      c_d.irqSelect = defIrq;
      for (int i = 0; i < strap_config_pkg::NUM_DEV; i++)
      begin
        c_d.baseHigh[i] = defBase[i*16+8 +: 8];
        c_d.baseLow[i] = defBase[i*16 +: 8];
      end
    end
    else if (ioWrite && hitIndex)
    begin
      case (c_q.state)
        strap_config_pkg::LOCKED:
        begin
          if (ioWrData == entryKey)
          begin
            c_d.state = strap_config_pkg::KEY_SEEN;
          end
        end
        strap_config_pkg::KEY_SEEN:
        begin
          if (ioWrData == entryKey)
          begin
            c_d.state = strap_config_pkg::CONFIG_OPEN;
          end
          else
          begin
            c_d.state = strap_config_pkg::LOCKED;
          end
        end
        strap_config_pkg::CONFIG_OPEN:
        begin
          if (ioWrData == `EXIT_CODE)
          begin
            c_d.state = strap_config_pkg::LOCKED;
          end
          else
          begin
            c_d.index = ioWrData;
          end
        end
        default:
        begin
          c_d.state = strap_config_pkg::LOCKED;
        end
      endcase
    end
    else if (ioWrite && hitData)
    begin
      if (c_q.index == `IDX_DEVICE_SELECT)
      begin
        c_d.deviceSelect = ioWrData;
      end
      else if (c_q.index == `IDX_CLOCK_SELECT)
      begin
        c_d.clockSelect = ioWrData;
      end
      else if (c_q.index == `IDX_ENABLE && slotValid)
      begin
        c_d.enable[slot] = ioWrData[0];
      end
      else if (c_q.index == `IDX_BASE_HIGH && slotValid)
      begin
        c_d.baseHigh[slot] = ioWrData;
      end
      else if (c_q.index == `IDX_BASE_LOW && slotValid)
      begin
        c_d.baseLow[slot] = ioWrData;
      end
      else if (c_q.index == `IDX_IRQ_SELECT && slotValid)
      begin
        c_d.irqSelect[slot] = ioWrData;
      end
      else if (c_q.index == `IDX_FIFO_MODE && isChan)
      begin
        c_d.fifoMode[slot[1:0]] = ioWrData;
      end
    end
    // Reads return the index on the index port and a register on the data port.
    if (ioRead && hitIndex && c_q.state == strap_config_pkg::CONFIG_OPEN)
    begin
      c_d.rdValid = 1'b1;
      c_d.rdData = c_q.index;
    end
    else if (ioRead && hitData)
    begin
      c_d.rdValid = 1'b1;
      c_d.rdData = 8'h00;
      if (c_q.index == `IDX_ID_HIGH)
      begin
        c_d.rdData = ID_HIGH;
      end
      else if (c_q.index == `IDX_ID_LOW)
      begin
        c_d.rdData = ID_LOW;
      end
      else if (c_q.index == `IDX_DEVICE_SELECT)
      begin
        c_d.rdData = c_q.deviceSelect;
      end
      else if (c_q.index == `IDX_CLOCK_SELECT)
      begin
        c_d.rdData = c_q.clockSelect;
      end
      else if (c_q.index == `IDX_ENABLE && slotValid)
      begin
        c_d.rdData = {7'd0, c_q.enable[slot]};
      end
      else if (c_q.index == `IDX_BASE_HIGH && slotValid)
      begin
        c_d.rdData = c_q.baseHigh[slot];
      end
      else if (c_q.index == `IDX_BASE_LOW && slotValid)
      begin
        c_d.rdData = c_q.baseLow[slot];
      end
      else if (c_q.index == `IDX_IRQ_SELECT && slotValid)
      begin
        c_d.rdData = c_q.irqSelect[slot];
      end
      else if (c_q.index == `IDX_FIFO_MODE && isChan)
      begin
        c_d.rdData = c_q.fifoMode[slot[1:0]];
      end
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  // Reset clears everything but the state, which goes to LOCKED; strap values arrive on the second edge after release via loadPulse.
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      c_q <= '0;
      c_q.state <= strap_config_pkg::LOCKED;
      c_q.clockSelect <= `CLOCK_SELECT_RESET;
      c_q.fifoMode <= {strap_config_pkg::NUM_CHAN{`FIFO_MODE_RESET}};
    end
    else
    begin
      c_q <= c_d;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign ioRdData = c_q.rdData;
  assign ioRdValid = c_q.rdValid;
  assign configMode = (c_q.state == strap_config_pkg::CONFIG_OPEN);
  assign clockSelect48 = c_q.clockSelect[0];
  assign devEnable = c_q.enable;

  genvar g;
  generate
    for (g = 0; g < strap_config_pkg::NUM_DEV; g++)
    begin : g_dev
      assign devBase[g*16 +: 16] = {c_q.baseHigh[g], c_q.baseLow[g]};
      assign devIrqSelect[g*8 +: 8] = c_q.irqSelect[g];
    end
    for (g = 0; g < strap_config_pkg::NUM_CHAN; g++)
    begin : g_chan
      assign chanFifoMode[g*8 +: 8] = c_q.fifoMode[g];
      assign chanFifoDeep[g] = (c_q.fifoMode[g][1:0] == `FIFO_DEEP_CODE);
    end
  endgenerate
endmodule
`default_nettype wire

// >>> core/strap_sampler.sv
// Strap capture after reset release and decode of strap-derived defaults.
`include "strap_config_params.svh"
`default_nettype none
module strap_sampler
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic chanAStrap,
  input wire logic chanAAltStrap,
  input wire logic chanBStrap,
  input wire logic chanBAltStrap,
  input wire logic chanCStrap,
  input wire logic chanDStrap,
  input wire logic watchdogStrap,
  input wire logic configPortStrap,
  input wire logic entryKeyStrapHi,
  input wire logic entryKeyStrapLo,
  output logic loadPulse,
  output logic configPortHigh,
  output logic [7:0] entryKey,
  output logic [4:0] defEnable,
  output logic [79:0] defBase,
  output logic [39:0] defIrq
);
  strap_config_pkg::sampler_s s_q;
  strap_config_pkg::sampler_s s_d;
  logic [9:0] st;

  // ----------------------------------------------------------------------
  // Capture
  // ----------------------------------------------------------------------
  // Straps are caught on the first edge after release, never by the reset itself.
  always_comb
  begin
    s_d = s_q;
    s_d.pulse = 1'b0;
    if (!s_q.done)
    begin
      s_d.done = 1'b1;
      s_d.pulse = 1'b1;
      s_d.straps = {entryKeyStrapHi, entryKeyStrapLo, configPortStrap, watchdogStrap,
        chanDStrap, chanCStrap, chanBAltStrap, chanBStrap, chanAAltStrap, chanAStrap};
    end
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  assign st = s_q.straps;
  assign loadPulse = s_q.pulse;
  assign configPortHigh = st[7];

  always_comb
  begin
    case (st[9:8])
      2'b00: entryKey = `KEY_CODE_00;
      2'b01: entryKey = `KEY_CODE_01;
      2'b10: entryKey = `KEY_CODE_10;
      default: entryKey = `KEY_CODE_11;
    endcase
  end

  always_comb
  begin
    defEnable = {st[6], st[5], st[4], st[3] | st[2], st[1] | st[0]};
    defBase = '0;
    defIrq = '0;
    if (st[0])
    begin
      defBase[15:0] = `BASE_CHAN_A;
    end
    else if (st[1])
    begin
      defBase[15:0] = `BASE_CHAN_A_ALT;
    end
    if (st[0] | st[1])
    begin
      defIrq[7:0] = `IRQ_CHAN_A;
    end
    if (st[2])
    begin
      defBase[31:16] = `BASE_CHAN_B;
    end
    else if (st[3])
    begin
      defBase[31:16] = `BASE_CHAN_B_ALT;
    end
    if (st[2] | st[3])
    begin
      defIrq[15:8] = `IRQ_CHAN_B;
    end
    if (st[4])
    begin
      defBase[47:32] = `BASE_CHAN_C;
      defIrq[23:16] = `IRQ_CHAN_C;
    end
    if (st[5])
    begin
      defBase[63:48] = `BASE_CHAN_D;
      defIrq[31:24] = `IRQ_CHAN_D;
    end
    if (st[6])
    begin
      defBase[79:64] = `BASE_WATCHDOG;
      defIrq[39:32] = `IRQ_WATCHDOG;
    end
  end
endmodule
`default_nettype wire

// >>> tb/lpc_host_model.sv
// Host model issuing decoded I/O read and write cycles.
`default_nettype none
module lpc_host_model
(
  input wire logic clock,
  output logic ioWrite,
  output logic ioRead,
  output logic [15:0] ioAddr,
  output logic [7:0] ioWrData,
  input wire logic [7:0] ioRdData,
  input wire logic ioRdValid
);
  timeunit 1ns;
  timeprecision 100ps;
  int gap = 0;
  initial
  begin
    ioWrite = 1'b0;
    ioRead = 1'b0;
    ioAddr = 16'h0000;
    ioWrData = 8'h00;
  end
  // Released address and data lines show the inverse of the last value, so no stale copy can pass.
  task automatic release_bus();
    ioWrite = 1'b0;
    ioRead = 1'b0;
    ioAddr = ~ioAddr;
    ioWrData = ~ioWrData;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d, input bit twice = 0);
    repeat (gap + 1) @(posedge clock);
    #1;
    ioAddr = a;
    ioWrData = d;
    ioWrite = 1'b1;
    repeat (twice ? 2 : 1) @(posedge clock);
    #1;
    release_bus();
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic ok);
    repeat (gap + 1) @(posedge clock);
    #1;
    ioAddr = a;
    ioRead = 1'b1;
    @(posedge clock);
    #1;
    release_bus();
    ok = ioRdValid;
    d = ioRdData;
  endtask
  task automatic cfg_wr(input logic [7:0] idx, input logic [7:0] d);
    wr(16'h002e, idx);
    wr(16'h002f, d);
  endtask
endmodule
`default_nettype wire

// >>> tb/strap_config_port_access_properties.sv
// Checker for strap capture and the index/data configuration ports.
`default_nettype none
module strap_config_props
#(
  parameter logic [7:0] ID_HIGH = 8'h5a
)
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic ioWrite,
  input wire logic ioRead,
  input wire logic [15:0] ioAddr,
  input wire logic [7:0] ioWrData,
  input wire logic ioClaim,
  input wire logic [7:0] ioRdData,
  input wire logic ioRdValid,
  input wire logic chanAStrap,
  input wire logic chanAAltStrap,
  input wire logic chanBStrap,
  input wire logic chanBAltStrap,
  input wire logic chanCStrap,
  input wire logic chanDStrap,
  input wire logic watchdogStrap,
  input wire logic configPortStrap,
  input wire logic entryKeyStrapHi,
  input wire logic entryKeyStrapLo,
  input wire logic configMode,
  input wire logic clockSelect48,
  input wire logic [4:0] devEnable,
  input wire logic [79:0] devBase,
  input wire logic [31:0] chanFifoMode,
  input wire logic [3:0] chanFifoDeep
);
  logic [15:0] idxPort;
  logic [7:0] key;
  logic [7:0] idxQ;
  logic [1:0] cntQ;
  logic idxWr;
  logic datWr;
  assign idxPort = configPortStrap ? 16'h002e : 16'h004e;
  assign key = entryKeyStrapHi ? (entryKeyStrapLo ? 8'h67 : 8'h87)
                               : (entryKeyStrapLo ? 8'ha0 : 8'h77);
  assign idxWr = ioWrite && ioAddr == idxPort;
  assign datWr = configMode && ioWrite && ioAddr == idxPort + 16'h0001;
  // The index is shadowed here because the block does not show it at its ports.
  always_ff @(posedge clock or negedge rstn)
    if (!rstn)
    begin
      idxQ <= 8'h00;
      cntQ <= 2'h0;
    end
    else
    begin
      if (configMode && idxWr && ioWrData != 8'haa)
        idxQ <= ioWrData;
      if (cntQ != 2'h3)
        cntQ <= cntQ + 2'h1;
    end
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);
  a_locked_data_ignored:
    assert property (!configMode && (ioWrite || ioRead) && ioAddr == idxPort + 16'h0001
      |-> !ioClaim) else $error("data port claimed while locked");
  a_read_valid_next:
    assert property (configMode && ioRead && ioClaim |=> ioRdValid)
      else $error("read not answered");
  a_valid_has_cause:
    assert property (ioRdValid |-> $past(ioRead && ioClaim)) else $error("stray read valid");
  a_key_pair_opens:
    assert property (idxWr && ioWrData == key ##1 idxWr && ioWrData == key |=> configMode)
      else $error("key pair did not open");
  a_open_after_key:
    assert property ($rose(configMode) |-> $past(idxWr && ioWrData == key))
      else $error("opened without key");
  a_exit_closes:
    assert property (configMode && idxWr && ioWrData == 8'haa |=> !configMode)
      else $error("exit code ignored");
  a_clock_select:
    assert property (datWr && idxQ == 8'h25 |=> clockSelect48 == $past(ioWrData[0]))
      else $error("clock select not written");
  a_id_high_read:
    assert property (configMode && ioRead && ioClaim && ioAddr != idxPort && idxQ == 8'h20
      |=> ioRdData == ID_HIGH) else $error("wrong id high byte");
  a_fifo_deep:
    assert property (chanFifoDeep == {chanFifoMode[25:24] == 2'h3, chanFifoMode[17:16] == 2'h3,
      chanFifoMode[9:8] == 2'h3, chanFifoMode[1:0] == 2'h3}) else $error("fifo depth wrong");
  a_strap_enable:
    assert property (cntQ == 2'h2 |-> devEnable == {watchdogStrap, chanDStrap, chanCStrap,
      chanBStrap || chanBAltStrap, chanAStrap || chanAAltStrap}) else $error("strap enable");
  a_strap_base:
    assert property (cntQ == 2'h2 |-> devBase[15:0] == (chanAStrap ? 16'h03f8
      : chanAAltStrap ? 16'h03e0 : 16'h0000)) else $error("strap base wrong");
  cover property ($rose(configMode));
  cover property ($fell(configMode));
  cover property (ioRdValid && configMode);
endmodule
bind strap_config_port_access strap_config_props #(.ID_HIGH(ID_HIGH)) u_strap_config_props
(
  .clock, .rstn, .ioWrite, .ioRead, .ioAddr, .ioWrData, .ioClaim, .ioRdData, .ioRdValid,
  .chanAStrap, .chanAAltStrap, .chanBStrap, .chanBAltStrap, .chanCStrap, .chanDStrap,
  .watchdogStrap, .configPortStrap, .entryKeyStrapHi, .entryKeyStrapLo, .configMode,
  .clockSelect48, .devEnable, .devBase, .chanFifoMode, .chanFifoDeep
);
`default_nettype wire

// >>> tb/tb_top.sv
// Self-checking bench for strap capture and configuration port access.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0] IDH = 8'h5a;
  localparam logic [7:0] IDL = 8'h01;
  logic clock, rstn, ioWrite, ioRead, ioClaim, ioRdValid, configMode, clockSelect48, rdOk;
  logic [15:0] ioAddr, port;
  logic [7:0] ioWrData, ioRdData, rdD;
  logic [9:0] straps;
  logic [4:0] devEnable;
  logic [79:0] devBase;
  logic [39:0] devIrqSelect;
  logic [31:0] chanFifoMode;
  logic [3:0] chanFifoDeep;
  logic [7:0] keys [4] = '{8'h77, 8'ha0, 8'h87, 8'h67};
  int n_errors = 0;
  int checked = 0;
  int cyc = 0;
  strap_config_port_access #(.ID_HIGH(IDH), .ID_LOW(IDL)) u_strap_config_port_access
  (
    .clock, .rstn, .ioWrite, .ioRead, .ioAddr, .ioWrData, .ioClaim, .ioRdData, .ioRdValid,
    .chanAStrap(straps[0]), .chanAAltStrap(straps[1]), .chanBStrap(straps[2]),
    .chanBAltStrap(straps[3]), .chanCStrap(straps[4]), .chanDStrap(straps[5]),
    .watchdogStrap(straps[6]), .configPortStrap(straps[7]), .entryKeyStrapLo(straps[8]),
    .entryKeyStrapHi(straps[9]), .configMode, .clockSelect48, .devEnable, .devBase,
    .devIrqSelect, .chanFifoMode, .chanFifoDeep
  );
  lpc_host_model u_lpc_host_model
  (
    .clock, .ioWrite, .ioRead, .ioAddr, .ioWrData, .ioRdData, .ioRdValid
  );
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_errors++;
      $display("ERROR %0t run too long", $time);
      results();
    end
  end
  task automatic check(input logic [79:0] got, input logic [79:0] exp, input string what);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic do_reset(input logic [9:0] s);
    @(posedge clock);
    #1;
    rstn = 1'b0;
    straps = s;
    repeat (4) @(posedge clock);
    #1;
    rstn = 1'b1;
    repeat (2) @(posedge clock);
    #1;
  endtask
  task automatic rd_reg(input logic [7:0] idx, input logic [7:0] exp, input string what);
    u_lpc_host_model.wr(16'h002e, idx);
    u_lpc_host_model.rd(16'h002f, rdD, rdOk);
    check(80'({rdOk, rdD}), 80'({1'b1, exp}), what);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic test_straps();
    do_reset(10'h3ff);
    check(80'(devEnable), 80'h1f, "enable all high");
    check(devBase, {16'h0442, 16'h02e8, 16'h03e8, 16'h02f8, 16'h03f8}, "bases");
    check(80'(devIrqSelect), 80'h00_0905_0403, "irq lines");
    do_reset(10'h00a);
    check(80'(devEnable), 80'h03, "enable alt only");
    check(devBase, {48'h0, 16'h02e0, 16'h03e0}, "alt bases");
    check(80'(devIrqSelect), 80'h0404_0403 & 80'h0000_ffff, "alt irq lines");
    $display("test straps done");
  endtask
  task automatic test_keys();
    for (int k = 0; k < 4; k++)
    begin
      do_reset({k[1:0], k[0], 7'h7f});
      port = k[0] ? 16'h002e : 16'h004e;
      u_lpc_host_model.rd(port + 16'h0001, rdD, rdOk);
      check(80'(rdOk), 80'h0, "locked data read");
      u_lpc_host_model.wr(port ^ 16'h0060, keys[k], 1);
      check(80'(configMode), 80'h0, "other port pair");
      u_lpc_host_model.wr(port, keys[k]);
      u_lpc_host_model.wr(port, 8'h11);
      u_lpc_host_model.wr(port, keys[k]);
      check(80'(configMode), 80'h0, "broken pair");
      u_lpc_host_model.wr(port, 8'h11);
      u_lpc_host_model.wr(port, keys[k], 1);
      check(80'(configMode), 80'h1, "key pair");
      u_lpc_host_model.wr(port, 8'haa);
      check(80'(configMode), 80'h0, "exit");
    end
    $display("test keys done");
  endtask
  task automatic test_regs();
    do_reset(10'h3ff);
    u_lpc_host_model.gap = 2;
    u_lpc_host_model.wr(16'h002e, 8'h67, 1);
    u_lpc_host_model.gap = 0;
    rd_reg(8'h20, IDH, "id high");
    rd_reg(8'h21, IDL, "id low");
    u_lpc_host_model.cfg_wr(8'h25, 8'h01);
    check(80'(clockSelect48), 80'h1, "fast clock");
    u_lpc_host_model.cfg_wr(8'h25, 8'h00);
    check(80'(clockSelect48), 80'h0, "slow clock");
    u_lpc_host_model.cfg_wr(8'h07, 8'h01);
    u_lpc_host_model.cfg_wr(8'hf6, 8'h03);
    check(80'(chanFifoDeep), 80'h2, "deep fifo");
    check(80'(chanFifoMode), 80'h0300, "fifo mode slot");
    rd_reg(8'h07, 8'h01, "selector");
    u_lpc_host_model.cfg_wr(8'h07, 8'h00);
    u_lpc_host_model.cfg_wr(8'h60, 8'h12);
    u_lpc_host_model.cfg_wr(8'h61, 8'h34);
    u_lpc_host_model.cfg_wr(8'h70, 8'h07);
    check(80'(devBase[31:0]), 80'h02f8_1234, "base rewrite");
    check(80'(devIrqSelect[7:0]), 80'h07, "irq rewrite");
    u_lpc_host_model.cfg_wr(8'h30, 8'h00);
    check(80'(devEnable), 80'h1e, "disable");
    u_lpc_host_model.cfg_wr(8'h30, 8'h01);
    check(80'(devEnable), 80'h1f, "enable");
    u_lpc_host_model.wr(16'h002e, 8'haa);
    u_lpc_host_model.wr(16'h002f, 8'h00);
    check(80'(devEnable), 80'h1f, "write after exit");
    $display("test regs done");
  endtask
  task automatic results();
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    rstn = 1'b0;
    straps = 10'h3ff;
    test_straps();
    test_keys();
    test_regs();
    results();
  end
endmodule
`default_nettype wire
